/* File: tb/ahpc_mobo_model.sv */
// Motherboard power and reset switch inputs with their pull-ups
`timescale 1ns/1ps
module ahpc_mobo_model (
  // Block side of the two pins
  input logic pwr_o,
  input logic pwr_oe,
  input logic rst_o,
  input logic rst_oe,
  // Levels seen by the board
  output logic pwr_line,
  output logic rst_line
);
  // Pull-ups hold a floated input at its idle high level
  assign pwr_line = pwr_oe ? pwr_o : 1'b1;
  assign rst_line = rst_oe ? rst_o : 1'b1;
endmodule // ahpc_mobo_model

/* File: tb/ahpc_power_ctrl_asserts.sv */
// Port checker of the host power sequencer, bound to its top module
`timescale 1ns/1ps
module ahpc_asserts (
  // Clock and reset
  input logic CORE_CLK,
  input logic SYS_RST,
  // Bus handshake
  input logic WB_CYC_I,
  input logic WB_STB_I,
  input logic WB_ACK_O,
  // Sense, keys, watchdog
  input logic POWER_SENSE,
  input logic KEY_CONFIRM,
  input logic KEY_CANCEL,
  input logic WATCHDOG_FIRE,
  // Pins and outputs
  input logic PWR_SW_O,
  input logic PWR_SW_OE,
  input logic RST_SW_O,
  input logic RST_SW_OE,
  input logic DISPLAY_BLANK,
  input logic SELF_RESET,
  input logic [31:0] FAN_POWER
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_pwr_lvl; PWR_SW_OE && $past(PWR_SW_OE) |-> $stable(PWR_SW_O); endproperty
  a_pwr_lvl: assert property (p_pwr_lvl) else $error("power pin level moved");
  property p_rst_lvl; RST_SW_OE && $past(RST_SW_OE) |-> $stable(RST_SW_O); endproperty
  a_rst_lvl: assert property (p_rst_lvl) else $error("reset pin level moved");
  property p_excl; !(PWR_SW_OE && RST_SW_OE); endproperty
  a_excl: assert property (p_excl) else $error("both pins driven");
  property p_min; $rose(PWR_SW_OE) |-> PWR_SW_OE [*8]; endproperty
  a_min: assert property (p_min) else $error("power pulse too short");
  property p_cause; $rose(PWR_SW_OE) |-> $past(KEY_CONFIRM || KEY_CANCEL); endproperty
  a_cause: assert property (p_cause) else $error("power pulse without key");
  // Self reset may only follow the end of a host reset pulse
  property p_self;
    SELF_RESET |-> !RST_SW_OE && ($past(RST_SW_OE) || $past(RST_SW_OE, 2)) ##1 !SELF_RESET;
  endproperty
  a_self: assert property (p_self) else $error("self reset misplaced");
  property p_blank; POWER_SENSE |=> !DISPLAY_BLANK; endproperty
  a_blank: assert property (p_blank) else $error("blank while host on");
  property p_fan; $fell(POWER_SENSE) |=> $stable(FAN_POWER); endproperty
  a_fan: assert property (p_fan) else $error("fan power changed");
  property p_wdog;
    WATCHDOG_FIRE && !PWR_SW_OE && !RST_SW_OE && !KEY_CONFIRM && !KEY_CANCEL |-> ##[1:4] RST_SW_OE;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not driving reset");
  c_pwr: cover property ($rose(PWR_SW_OE));
  c_rst: cover property ($rose(RST_SW_OE));
  c_self: cover property (SELF_RESET);
endmodule // ahpc_asserts
bind ahpc_power_ctrl ahpc_asserts u_ahpc_asserts (.*);

/* File: tb/tb_ahpc_power_ctrl.sv */
// Self-checking bench of the host power sequencer
`timescale 1ns/1ps
module tb_ahpc_power_ctrl;
  localparam int ON = 10, HOLD = 20, EXT = 16, RP = 12;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sense = 0, kc = 0, kx = 0, wd = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdat, x = 32'h0000_001A;
  wire [31:0] dout, fan;
  wire ack, pso, psoe, rso, rsoe, blank, selfr, pline, rline;
  int fail_count = 0, compares = 0, n, w, k, lvl;
  ahpc_power_ctrl #(.ON_HOLD_CYC(ON), .OFF_HOLD_CYC(HOLD), .RST_HOLD_CYC(HOLD), .PULSE_CYC(16),
    .EXTRA_CYC(EXT), .RST_PULSE_CYC(RP)) u_ahpc_power_ctrl (.CORE_CLK(clk), .SYS_RST(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .POWER_SENSE(sense), .KEY_CONFIRM(kc),
    .KEY_CANCEL(kx), .WATCHDOG_FIRE(wd), .PWR_SW_I(pline), .PWR_SW_O(pso), .PWR_SW_OE(psoe),
    .RST_SW_I(rline), .RST_SW_O(rso), .RST_SW_OE(rsoe), .DISPLAY_BLANK(blank),
    .SELF_RESET(selfr), .FAN_POWER(fan));
  // Pins stay dedicated to the sequencer, never reused as general-purpose lines
  ahpc_mobo_model u_ahpc_mobo_model (.pwr_o(pso), .pwr_oe(psoe), .rst_o(rso), .rst_oe(rsoe),
    .pwr_line(pline), .rst_line(rline));
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic wrap_up;
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Single classic cycle; ack and read data are taken at the rising edge that sees ack
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, wr, a, d};
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    chk("ack", 1, ack);
    if (ack !== 1'b1) wrap_up();
    rdat = dout;
    {cyc, stb, we} <= 3'b000;
  endtask
  // Waits for a pin to be driven, then measures its length and wire level
  task automatic pulse(input bit r, output int len, output int lv);
    len = 0;
    repeat (300) begin
      @(negedge clk);
      if ((r ? rsoe : psoe) === 1'b1) break;
    end
    chk("drive", 1, r ? rsoe : psoe);
    if ((r ? rsoe : psoe) !== 1'b1) wrap_up();
    lv = r ? rline : pline;
    while ((r ? rsoe : psoe) === 1'b1 && len < 300) begin
      len++;
      @(negedge clk);
    end
  endtask
  // Holds a key for c cycles and counts any pin drive meanwhile
  task automatic idle_hold(input bit cancel, input int c);
    int q = 0;
    @(posedge clk) {kc, kx} <= cancel ? 2'b01 : 2'b10;
    repeat (c) @(negedge clk) q += psoe | rsoe;
    @(posedge clk) {kc, kx} <= 2'b00;
    chk("quiet", 0, q);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    wb(0, 8'h00, 0); chk("ctrl", 32'h0000_0000, rdat);
    wb(0, 8'h0C, 0); chk("fan", 32'hFFFF_FFFF, rdat);
    wb(1, 8'h10, 32'h1234_5678);
    wb(0, 8'h10, 0); chk("unmapped", 32'h0000_0000, rdat);
    idle_hold(0, ON + 20); chk("blank off", 0, blank);
    wb(1, 8'h00, 32'h0000_003D);
    wb(0, 8'h00, 0); chk("ctrl set", 32'h0000_003D, rdat);
    idle_hold(0, ON - 3); idle_hold(0, ON - 3);
    chk("blank on", 1, blank);
    for (k = 0; k < 2; k++) begin
      x = xs(x);
      w = k ? 8 + x[3:0] : 12;
      wb(1, 8'h04, w);
      wb(0, 8'h04, 0); chk("width", w, rdat);
      @(posedge clk) kc <= 1;
      pulse(0, n, lvl); chk("on len", w, n);
      chk("on level", 1, lvl);
      @(posedge clk) kc <= 0;
    end
    @(posedge clk) sense <= 1;
    repeat (3) @(negedge clk);
    chk("blank off", 0, blank);
    wb(0, 8'h08, 0); chk("status", 32'h0000_0001, rdat);
    x = xs(x);
    wb(1, 8'h0C, x);
    @(posedge clk) sense <= 0;
    repeat (3) @(posedge clk);
    chk("fan", x, fan);
    sense <= 1;
    @(posedge clk) kx <= 1;
    pulse(0, n, lvl); chk("off len", w + EXT, n);
    @(posedge clk) kx <= 0;
    @(posedge clk) kc <= 1;
    pulse(1, n, lvl); chk("rst len", RP, n);
    chk("rst level", 0, lvl);
    n = selfr;
    repeat (2) @(negedge clk) n += selfr;
    chk("self reset", 1, n);
    @(posedge clk) kc <= 0;
    wb(1, 8'h00, 32'h0000_002D);
    idle_hold(0, HOLD + 10);
    @(posedge clk) wd <= 1;
    @(posedge clk) wd <= 0;
    pulse(1, n, lvl); chk("wdog level", 0, lvl);
    wrap_up();
  end
endmodule // tb_ahpc_power_ctrl

/* File: verilog/ahpc_hold_timer.v */
// Key hold timer that reports once a key has been held for a threshold
`timescale 1ns/1ps
module ahpc_hold_timer #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire rst,
  input wire key,
  input wire arm,
  input wire [WIDTH-1:0] limit,
  output reg done
);
  reg [WIDTH-1:0] count;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (!key || !arm) begin
      // A short hold leaves no trace
      count <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (count + 1'b1 >= limit) begin
      done <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // ahpc_hold_timer

/* File: verilog/ahpc_power_ctrl.v */
// Front-panel host power and reset sequencer with Wishbone registers
`timescale 1ns/1ps
`include "ahpc_regs.vh"
module ahpc_power_ctrl #(
  parameter [31:0] ON_HOLD_CYC = `AHPC_ON_HOLD_CYC,
  parameter [31:0] OFF_HOLD_CYC = `AHPC_OFF_HOLD_CYC,
  parameter [31:0] RST_HOLD_CYC = `AHPC_RST_HOLD_CYC,
  parameter [31:0] PULSE_CYC = `AHPC_PULSE_CYC,
  parameter [31:0] EXTRA_CYC = `AHPC_EXTRA_CYC,
  parameter [31:0] RST_PULSE_CYC = `AHPC_RST_PULSE_CYC
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire SYS_RST,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Host sense, keys and watchdog
  input wire POWER_SENSE,
  input wire KEY_CONFIRM,
  input wire KEY_CANCEL,
  input wire WATCHDOG_FIRE,
  // Power-switch pin
  input wire PWR_SW_I,
  output reg PWR_SW_O,
  output reg PWR_SW_OE,
  // Reset-switch pin
  input wire RST_SW_I,
  output reg RST_SW_O,
  output reg RST_SW_OE,
  // Display and self reset
  output reg DISPLAY_BLANK,
  output reg SELF_RESET,
  // Fan power
  output reg [31:0] FAN_POWER
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ON_PULSE = 3'd1;
  localparam ST_OFF_PULSE = 3'd2;
  localparam ST_OFF_EXTRA = 3'd3;
  localparam ST_RST_PULSE = 3'd4;
  localparam ST_SELF_RST = 3'd5;
  localparam ST_WAIT_REL = 3'd6;

  reg [5:0] ctrl;
  reg [31:0] width;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] timer;
  reg [31:0] next_timer;
  reg wd_seen;
  wire hit_on;
  wire hit_off;
  wire hit_rst;
  wire host_on;
  wire bus_req;
  wire [31:0] pulse_len;

  // Pin inputs are not observed, not even through the bus; the pads are open when undriven
  assign host_on = POWER_SENSE;
  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // A zero width would drive the pin for one cycle only, so fall back to the documented width
  assign pulse_len = (width == 32'h0000_0000) ? PULSE_CYC : width;

  ahpc_hold_timer #(.WIDTH(32)) u_on_hold (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .key(KEY_CONFIRM),
    .arm(~host_on & ctrl[`AHPC_CTRL_EN_ON] & (state == ST_IDLE)),
    .limit(ON_HOLD_CYC),
    .done(hit_on)
  );

  ahpc_hold_timer #(.WIDTH(32)) u_off_hold (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .key(KEY_CANCEL),
    .arm(host_on & ctrl[`AHPC_CTRL_EN_OFF] & (state == ST_IDLE)),
    .limit(OFF_HOLD_CYC),
    .done(hit_off)
  );

  ahpc_hold_timer #(.WIDTH(32)) u_rst_hold (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .key(KEY_CONFIRM),
    .arm(host_on & ctrl[`AHPC_CTRL_EN_RST] & (state == ST_IDLE)),
    .limit(RST_HOLD_CYC),
    .done(hit_rst)
  );

  // Sequencer
  always @* begin
    next_state = state;
    next_timer = timer;
    case (state)
      ST_IDLE: begin
        next_timer = 32'h0000_0000;
        if (wd_seen) begin
          next_state = ST_RST_PULSE;
        end else if (hit_on) begin
          next_state = ST_ON_PULSE;
        end else if (hit_off) begin
          next_state = ST_OFF_PULSE;
        end else if (hit_rst) begin
          next_state = ST_RST_PULSE;
        end
      end
      ST_ON_PULSE: begin
        next_timer = timer + 32'h0000_0001;
        if (next_timer >= pulse_len) begin
          next_state = ST_WAIT_REL;
        end
      end
      ST_OFF_PULSE: begin
        next_timer = timer + 32'h0000_0001;
        if (next_timer >= pulse_len) begin
          next_timer = 32'h0000_0000;
          next_state = KEY_CANCEL ? ST_OFF_EXTRA : ST_WAIT_REL;
        end
      end
      ST_OFF_EXTRA: begin
        next_timer = timer + 32'h0000_0001;
        if (!KEY_CANCEL || next_timer >= EXTRA_CYC) begin
          next_state = ST_WAIT_REL;
        end
      end
      ST_RST_PULSE: begin
        next_timer = timer + 32'h0000_0001;
        if (next_timer >= RST_PULSE_CYC) begin
          next_state = ST_SELF_RST;
        end
      end
      ST_SELF_RST: begin
        next_state = ST_WAIT_REL;
      end
      ST_WAIT_REL: begin
        // Keys must be let go so one hold fires one action only
        next_timer = 32'h0000_0000;
        if (!KEY_CONFIRM && !KEY_CANCEL) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_timer = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
      timer <= 32'h0000_0000;
      wd_seen <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      // Watchdog request is held until the sequencer takes it; set wins
      if (WATCHDOG_FIRE) begin
        wd_seen <= 1'b1;
      end else if (state == ST_IDLE) begin
        wd_seen <= 1'b0;
      end
    end
  end

  // Pin drivers and display
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PWR_SW_O <= 1'b0;
      PWR_SW_OE <= 1'b0;
      RST_SW_O <= 1'b0;
      RST_SW_OE <= 1'b0;
      DISPLAY_BLANK <= 1'b0;
      SELF_RESET <= 1'b0;
    end else begin
      PWR_SW_OE <= (next_state == ST_ON_PULSE) || (next_state == ST_OFF_PULSE) ||
                   (next_state == ST_OFF_EXTRA);
      // Inactive level is high when not inverted, so the active drive is low
      PWR_SW_O <= ctrl[`AHPC_CTRL_PWR_INV];
      RST_SW_OE <= (next_state == ST_RST_PULSE);
      RST_SW_O <= ctrl[`AHPC_CTRL_RST_INV];
      SELF_RESET <= (next_state == ST_SELF_RST);
      DISPLAY_BLANK <= ctrl[`AHPC_CTRL_EN_BLANK] & ~host_on;
    end
  end

  // Wishbone slave: one registered ack per request, a cycle after the strobe
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl <= `AHPC_CTRL_RESET;
      width <= 32'h0000_0000;
      FAN_POWER <= 32'hFFFF_FFFF;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= 32'h0000_0000;
      if (bus_req && WB_WE_I) begin
        case (WB_ADR_I)
          `AHPC_CTRL_ADDR: begin
            if (WB_SEL_I[0]) begin
              ctrl <= WB_DAT_I[5:0];
            end
          end
          `AHPC_WIDTH_ADDR: begin
            if (WB_SEL_I[0]) width[7:0] <= WB_DAT_I[7:0];
            if (WB_SEL_I[1]) width[15:8] <= WB_DAT_I[15:8];
            if (WB_SEL_I[2]) width[23:16] <= WB_DAT_I[23:16];
            if (WB_SEL_I[3]) width[31:24] <= WB_DAT_I[31:24];
          end
          `AHPC_FAN_ADDR: begin
            // Only software moves the fan setting; sense never touches it
            if (WB_SEL_I[0]) FAN_POWER[7:0] <= WB_DAT_I[7:0];
            if (WB_SEL_I[1]) FAN_POWER[15:8] <= WB_DAT_I[15:8];
            if (WB_SEL_I[2]) FAN_POWER[23:16] <= WB_DAT_I[23:16];
            if (WB_SEL_I[3]) FAN_POWER[31:24] <= WB_DAT_I[31:24];
          end
          default: begin
          end
        endcase
      end else if (bus_req) begin
        case (WB_ADR_I)
          `AHPC_CTRL_ADDR: WB_DAT_O <= {26'h000_0000, ctrl};
          `AHPC_WIDTH_ADDR: WB_DAT_O <= pulse_len;
          `AHPC_STAT_ADDR: WB_DAT_O <= {25'h000_0000, state, DISPLAY_BLANK,
                                        RST_SW_OE, PWR_SW_OE, host_on};
          `AHPC_FAN_ADDR: WB_DAT_O <= FAN_POWER;
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Pin readbacks are left to the pad; is kept by software
  wire unused_pins;
  assign unused_pins = PWR_SW_I ^ RST_SW_I;
endmodule // ahpc_power_ctrl

/* File: verilog/ahpc_regs.vh */
// Register offsets, fields, reset values and timing constants of the power sequencer
`ifndef AHPC_REGS_VH
`define AHPC_REGS_VH
// Word byte addresses
`define AHPC_CTRL_ADDR 8'h00
`define AHPC_WIDTH_ADDR 8'h04
`define AHPC_STAT_ADDR 8'h08
`define AHPC_FAN_ADDR 8'h0C
// Control fields
`define AHPC_CTRL_PWR_INV 0
`define AHPC_CTRL_RST_INV 1
`define AHPC_CTRL_EN_ON 2
`define AHPC_CTRL_EN_OFF 3
`define AHPC_CTRL_EN_RST 4
`define AHPC_CTRL_EN_BLANK 5
`define AHPC_CTRL_RESET 6'h00
// Status fields
`define AHPC_STAT_SENSE 0
`define AHPC_STAT_PWR_DRV 1
`define AHPC_STAT_RST_DRV 2
`define AHPC_STAT_BLANK 3
`define AHPC_STAT_STATE 4
// Times in milliseconds and the clock rate in kHz
`define AHPC_CLK_KHZ 25000
`define AHPC_ON_HOLD_MS 250
`define AHPC_OFF_HOLD_MS 4000
`define AHPC_RST_HOLD_MS 4000
`define AHPC_PULSE_MS 1000
`define AHPC_EXTRA_MS 5000
`define AHPC_RST_PULSE_MS 1000
`define AHPC_ON_HOLD_CYC (`AHPC_ON_HOLD_MS * `AHPC_CLK_KHZ)
`define AHPC_OFF_HOLD_CYC (`AHPC_OFF_HOLD_MS * `AHPC_CLK_KHZ)
`define AHPC_RST_HOLD_CYC (`AHPC_RST_HOLD_MS * `AHPC_CLK_KHZ)
`define AHPC_PULSE_CYC (`AHPC_PULSE_MS * `AHPC_CLK_KHZ)
`define AHPC_EXTRA_CYC (`AHPC_EXTRA_MS * `AHPC_CLK_KHZ)
`define AHPC_RST_PULSE_CYC (`AHPC_RST_PULSE_MS * `AHPC_CLK_KHZ)
`endif
